// ===== src/mcu_interrupt_sequencer.sv
// Interrupt sequencer: request latching, priority, stacking and register file.
`include "irq_seq_consts.svh"

module mcu_interrupt_sequencer
	import irq_seq_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        awvalid_in,
	output logic             awready_out,
	input  wire logic [7:0]  awaddr_in,
	input  wire logic        wvalid_in,
	output logic             wready_out,
	input  wire logic [31:0] wdata_in,
	input  wire logic [3:0]  wstrb_in,
	output logic             bvalid_out,
	input  wire logic        bready_in,
	output logic [1:0]       bresp_out,
	input  wire logic        arvalid_in,
	output logic             arready_out,
	input  wire logic [7:0]  araddr_in,
	output logic             rvalid_out,
	input  wire logic        rready_in,
	output logic [31:0]      rdata_out,
	output logic [1:0]       rresp_out,
	input  wire logic        insn_boundary_in,
	input  wire logic        soft_trap_in,
	input  wire logic        return_in,
	input  wire logic        clear_mask_in,
	input  wire logic [15:0] pc_in,
	input  wire logic [7:0]  index_in,
	input  wire logic [7:0]  acc_in,
	input  wire logic [7:0]  flags_in,
	input  wire logic [7:0]  pull_data_in,
	input  wire logic        wait_mode_in,
	input  wire logic        stop_mode_in,
	input  wire logic        capture_event_in,
	input  wire logic        compare_event_in,
	input  wire logic        overflow_event_in,
	input  wire logic        byte_timer_zero_in,
	input  wire logic        shared_pin_a_in,
	input  wire logic        led_on_in,
	input  wire logic [3:0]  key_pins_in,
	output stack_push_t      push_out,
	output logic             vec_load_out,
	output logic [15:0]      vec_addr_out,
	output logic             pull_strobe_out,
	output logic [2:0]       pull_sel_out,
	output logic             busy_out,
	output logic             irq_mask_out,
	output logic             wake_out,
	output logic             shared_pin_a_oe_out,
	output logic [7:0]       pullup_en_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	logic [2:0] pin_a_sync_q;
	logic [3:0] key_meta_q;
	logic [3:0] key_sync_q;
	logic [3:0] key_last_q;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_a_sync_q <= 3'h7;
			key_meta_q   <= 4'hf;
			key_sync_q   <= 4'hf;
			key_last_q   <= 4'hf;
		end else begin
			pin_a_sync_q <= {pin_a_sync_q[1:0], shared_pin_a_in};
			key_meta_q   <= key_pins_in;
			key_sync_q   <= key_meta_q;
			key_last_q   <= key_sync_q;
		end
	end

	logic pin_a_level;
	logic pin_a_fall;
	assign pin_a_level = pin_a_sync_q[1];
	assign pin_a_fall  = pin_a_sync_q[2] & ~pin_a_sync_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Register state.

	logic [7:0] misc_ctrl_q;
	logic       cap_en_q;
	logic       cmp_en_q;
	logic       ovf_en_q;
	logic [7:0] t16_ctrl_q;
	logic       cap_flag_q;
	logic       cmp_flag_q;
	logic       ovf_flag_q;
	logic [2:0] t16_armed_q;
	logic       t8_flag_q;
	logic       t8_en_q;
	logic [3:0] key_flag_q;
	logic [3:0] key_en_q;
	logic [7:0] pullup_q;
	logic       ext_latch_q;
	logic       mask_q;

	logic       ext_en;
	logic       edge_only;
	assign ext_en    = misc_ctrl_q[`MISC_EXT_EN_BIT];
	assign edge_only = misc_ctrl_q[`MISC_EDGE_ONLY_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave.

	logic       have_aw_q;
	logic       have_w_q;
	logic [4:0] wr_idx_q;
	logic [7:0] wr_byte_q;
	logic       wr_lane_q;
	logic       do_wr;
	logic       do_rd;
	logic [4:0] rd_idx;
	logic       wr_hit;
	logic       rd_hit;
	logic [7:0] rd_byte;

	assign do_wr  = have_aw_q & have_w_q & ~bvalid_out;
	assign do_rd  = arvalid_in & arready_out;
	assign rd_idx = araddr_in[6:2];

	function automatic logic mapped(input logic [7:0] addr);
		logic [4:0] idx;
		idx = addr[6:2];
		mapped = ~addr[7] & (idx == `IDX_KEY_ENABLE || idx == `IDX_KEY_FLAG
			|| idx == `IDX_BYTE_TIMER || idx == `IDX_T16_CONTROL
			|| idx == `IDX_T16_STATUS || idx == `IDX_CAPTURE_LOW
			|| idx == `IDX_COMPARE_LOW || idx == `IDX_COUNTER_LOW
			|| idx == `IDX_MISC_CTRL || idx == `IDX_PULLUP_ENABLE);
	endfunction : mapped

	assign wr_hit = do_wr & wr_lane_q;
	assign rd_hit = do_rd & mapped(araddr_in);

	always_comb begin
		rd_byte = 8'h00;
		unique case (rd_idx)
			`IDX_KEY_ENABLE:    rd_byte = {4'h0, key_en_q};
			`IDX_KEY_FLAG:      rd_byte = {4'h0, key_flag_q};
			`IDX_BYTE_TIMER:    rd_byte = {t8_flag_q, t8_en_q, 6'h00};
			`IDX_T16_CONTROL:   rd_byte = t16_ctrl_q;
			`IDX_T16_STATUS:    rd_byte = {cap_flag_q, cmp_flag_q, ovf_flag_q, 5'h00};
			`IDX_MISC_CTRL:     rd_byte = misc_ctrl_q;
			`IDX_PULLUP_ENABLE: rd_byte = pullup_q;
			default:            rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			awready_out <= 1'b1;
			wready_out  <= 1'b1;
			have_aw_q   <= 1'b0;
			have_w_q    <= 1'b0;
			wr_idx_q    <= 5'h00;
			wr_byte_q   <= 8'h00;
			wr_lane_q   <= 1'b0;
			bvalid_out  <= 1'b0;
			bresp_out   <= `RESP_OKAY;
		end else begin
			if (awvalid_in && awready_out) begin
				awready_out <= 1'b0;
				have_aw_q   <= 1'b1;
				wr_idx_q    <= awaddr_in[6:2];
				wr_lane_q   <= mapped(awaddr_in);
			end
			if (wvalid_in && wready_out) begin
				wready_out <= 1'b0;
				have_w_q   <= 1'b1;
				wr_byte_q  <= wstrb_in[0] ? wdata_in[7:0] : 8'h00;
			end
			if (do_wr) begin
				have_aw_q  <= 1'b0;
				have_w_q   <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out  <= wr_lane_q ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_out && bready_in) begin
				bvalid_out  <= 1'b0;
				awready_out <= 1'b1;
				wready_out  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arready_out <= 1'b1;
			rvalid_out  <= 1'b0;
			rdata_out   <= 32'h0000_0000;
			rresp_out   <= `RESP_OKAY;
		end else if (do_rd) begin
			arready_out <= 1'b0;
			rvalid_out  <= 1'b1;
			rdata_out   <= {24'h00_0000, rd_hit ? rd_byte : 8'h00};
			rresp_out   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_out && rready_in) begin
			rvalid_out  <= 1'b0;
			arready_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers.

	// Byte-lane 0 alone carries the 8-bit registers; other lanes are ignored.
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			misc_ctrl_q <= 8'h00;
			key_en_q    <= 4'h0;
			t8_en_q     <= 1'b0;
			pullup_q    <= 8'h00;
		end else if (wr_hit) begin
			unique case (wr_idx_q)
				`IDX_MISC_CTRL:     misc_ctrl_q <= {4'h0, wr_byte_q[3:0]};
				`IDX_KEY_ENABLE:    key_en_q    <= wr_byte_q[3:0];
				`IDX_BYTE_TIMER:    t8_en_q     <= wr_byte_q[`T8_EN_BIT];
				`IDX_PULLUP_ENABLE: pullup_q    <= wr_byte_q;
				default:            ;
			endcase
		end
	end

	// These enables keep their value over reset, so they have no reset branch.
	always_ff @(posedge core_clk_in) begin
		if (wr_hit && wr_idx_q == `IDX_MISC_CTRL) begin
			cap_en_q <= wr_byte_q[`MISC_CAP_EN_BIT];
			cmp_en_q <= wr_byte_q[`MISC_CMP_EN_BIT];
		end
		if (wr_hit && wr_idx_q == `IDX_T16_CONTROL) begin
			ovf_en_q   <= wr_byte_q[`T16_OVF_EN_BIT];
			t16_ctrl_q <= wr_byte_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timer flags; a setting event always beats a clear in the same cycle.

	logic       status_rd;
	logic [2:0] low_touch;
	logic [2:0] t16_flags;
	logic [2:0] t16_events;
	logic [2:0] t16_clear;

	assign status_rd  = rd_hit & rd_idx == `IDX_T16_STATUS;
	assign low_touch[2] = rd_hit & rd_idx == `IDX_CAPTURE_LOW;
	assign low_touch[1] = (rd_hit & rd_idx == `IDX_COMPARE_LOW)
		| (wr_hit & wr_idx_q == `IDX_COMPARE_LOW);
	assign low_touch[0] = (rd_hit & rd_idx == `IDX_COUNTER_LOW)
		| (wr_hit & wr_idx_q == `IDX_COUNTER_LOW);
	assign t16_flags  = {cap_flag_q, cmp_flag_q, ovf_flag_q};
	assign t16_events = {capture_event_in, compare_event_in, overflow_event_in};
	assign t16_clear  = t16_armed_q & low_touch;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cap_flag_q  <= 1'b0;
			cmp_flag_q  <= 1'b0;
			ovf_flag_q  <= 1'b0;
			t16_armed_q <= 3'h0;
		end else begin
			cap_flag_q  <= capture_event_in | (cap_flag_q & ~t16_clear[2]);
			cmp_flag_q  <= compare_event_in | (cmp_flag_q & ~t16_clear[1]);
			ovf_flag_q  <= overflow_event_in | (ovf_flag_q & ~t16_clear[0]);
			t16_armed_q <= (t16_armed_q | ({3{status_rd}} & t16_flags))
				& ~t16_clear & ~t16_events;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			t8_flag_q <= 1'b0;
		end else begin
			t8_flag_q <= byte_timer_zero_in | (t8_flag_q & ~(wr_hit
				& wr_idx_q == `IDX_BYTE_TIMER & wr_byte_q[`T8_FLAG_BIT]));
		end
	end

	// Flags follow edges whatever the pins are used for, so software clears them first.
	generate
		for (genvar k = 0; k < 4; k++) begin : g_key
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					key_flag_q[k] <= 1'b0;
				end else begin
					key_flag_q[k] <= (key_last_q[k] & ~key_sync_q[k])
						| (key_flag_q[k] & ~(wr_hit & wr_idx_q == `IDX_KEY_FLAG
						& wr_byte_q[k]));
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// External request latch.

	seq_state_t state_q;
	logic       take_ext_q;
	logic       ext_clear;
	logic       ext_set;

	assign ext_clear = state_q == SEQ_VECTOR & take_ext_q;
	// Level mode re-asserts every cycle the pin is low, so a held line stays pending.
	assign ext_set   = pin_a_fall | (~edge_only & ~pin_a_level);

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_latch_q <= 1'b0;
		end else begin
			ext_latch_q <= ext_set | (ext_latch_q & ~ext_clear);
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shared_pin_a_oe_out <= 1'b0;
			pullup_en_out       <= 8'h00;
		end else begin
			shared_pin_a_oe_out <= led_on_in & ~ext_en;
			pullup_en_out       <= pullup_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request gathering, priority and wake-up.

	irq_req_t req;
	logic     any_req;
	logic     t16_req;
	logic     key_req;
	logic     take_any;

	assign t16_req = (cap_flag_q & cap_en_q) | (cmp_flag_q & cmp_en_q)
		| (ovf_flag_q & ovf_en_q);
	assign key_req = |(key_flag_q & key_en_q);
	assign req     = '{ext: ext_latch_q & ext_en, t16: t16_req,
		t8: t8_flag_q & t8_en_q, key: key_req};
	assign any_req = req.ext | req.t16 | req.t8 | req.key;
	// Masked requests simply stay latched and are taken once the mask drops.
	assign take_any = insn_boundary_in & ~mask_q & any_req;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wake_out <= 1'b0;
		end else begin
			wake_out <= (wait_mode_in & (req.ext | req.t16 | req.t8 | req.key))
				| (stop_mode_in & (req.ext | req.key));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Entry and return sequencer.

	logic [2:0]  step_q;
	logic [15:0] vec_sel_q;
	logic [2:0]  last_step;

	assign last_step = `STACK_BYTES - 3'h1;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q      <= SEQ_IDLE;
			step_q       <= 3'h0;
			vec_sel_q    <= `VEC_SOFT;
			take_ext_q   <= 1'b0;
			busy_out     <= 1'b0;
			push_out     <= '0;
			vec_load_out <= 1'b0;
			vec_addr_out <= 16'h0000;
			pull_strobe_out <= 1'b0;
			pull_sel_out <= 3'h0;
		end else begin
			push_out.strobe <= 1'b0;
			vec_load_out    <= 1'b0;
			pull_strobe_out <= 1'b0;
			unique case (state_q)
				SEQ_IDLE: begin
					step_q <= 3'h0;
					if (insn_boundary_in && return_in) begin
						state_q  <= SEQ_PULL;
						busy_out <= 1'b1;
					end else if (insn_boundary_in && soft_trap_in) begin
						state_q    <= SEQ_PUSH;
						busy_out   <= 1'b1;
						vec_sel_q  <= `VEC_SOFT;
						take_ext_q <= 1'b0;
					end else if (take_any) begin
						state_q    <= SEQ_PUSH;
						busy_out   <= 1'b1;
						take_ext_q <= req.ext;
						if (req.ext) begin
							vec_sel_q <= `VEC_EXT;
						end else if (req.t16) begin
							vec_sel_q <= `VEC_T16;
						end else if (req.t8) begin
							vec_sel_q <= `VEC_T8;
						end else begin
							vec_sel_q <= `VEC_KEY;
						end
					end
				end
				SEQ_PUSH: begin
					push_out.strobe <= 1'b1;
					unique case (step_q)
						3'h0:    push_out.data <= pc_in[7:0];
						3'h1:    push_out.data <= pc_in[15:8];
						3'h2:    push_out.data <= index_in;
						3'h3:    push_out.data <= acc_in;
						default: push_out.data <= {flags_in[7:4], mask_q, flags_in[2:0]};
					endcase
					step_q <= step_q + 3'h1;
					if (step_q == last_step) begin
						state_q <= SEQ_VECTOR;
					end
				end
				SEQ_VECTOR: begin
					vec_load_out <= 1'b1;
					vec_addr_out <= vec_sel_q;
					state_q      <= SEQ_IDLE;
					busy_out     <= 1'b0;
				end
				SEQ_PULL: begin
					pull_strobe_out <= 1'b1;
					pull_sel_out    <= step_q;
					step_q          <= step_q + 3'h1;
					if (step_q == last_step) begin
						state_q  <= SEQ_IDLE;
						busy_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// The mask is set together with the last push, one cycle before the vector load.
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mask_q       <= 1'b1;
			irq_mask_out <= 1'b1;
		end else begin
			if (state_q == SEQ_PUSH && step_q == last_step) begin
				mask_q       <= 1'b1;
				irq_mask_out <= 1'b1;
			end else if (pull_strobe_out && pull_sel_out == 3'h0) begin
				mask_q       <= pull_data_in[`FLAGS_MASK_BIT];
				irq_mask_out <= pull_data_in[`FLAGS_MASK_BIT];
			end else if (clear_mask_in) begin
				mask_q       <= 1'b0;
				irq_mask_out <= 1'b0;
			end
		end
	end

endmodule : mcu_interrupt_sequencer

// ===== src/irq_seq_consts.svh
// Register indexes, field positions and vector addresses of the interrupt sequencer.
`ifndef IRQ_SEQ_CONSTS_SVH
`define IRQ_SEQ_CONSTS_SVH

`define IDX_KEY_ENABLE     5'h0b
`define IDX_KEY_FLAG       5'h0c
`define IDX_BYTE_TIMER     5'h0d
`define IDX_T16_CONTROL    5'h12
`define IDX_T16_STATUS     5'h13
`define IDX_CAPTURE_LOW    5'h14
`define IDX_COMPARE_LOW    5'h15
`define IDX_COUNTER_LOW    5'h16
`define IDX_MISC_CTRL      5'h1c
`define IDX_PULLUP_ENABLE  5'h1d

`define MISC_EXT_EN_BIT    0
`define MISC_EDGE_ONLY_BIT 1
`define MISC_CAP_EN_BIT    2
`define MISC_CMP_EN_BIT    3
`define T16_OVF_EN_BIT     5
`define T16_CAP_FLAG_BIT   7
`define T16_CMP_FLAG_BIT   6
`define T16_OVF_FLAG_BIT   5
`define T8_FLAG_BIT        7
`define T8_EN_BIT          6
`define FLAGS_MASK_BIT     3

`define VEC_SOFT           16'h1ffc
`define VEC_EXT            16'h1ffa
`define VEC_T16            16'h1ff8
`define VEC_T8             16'h1ff6
`define VEC_KEY            16'h1ff4

`define STACK_BYTES        3'h5
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== src/irq_seq_pkg.sv
// Types shared by the interrupt sequencer.
package irq_seq_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_PUSH,
		SEQ_VECTOR,
		SEQ_PULL
	} seq_state_t;

	typedef struct packed {
		logic       strobe;
		logic [7:0] data;
	} stack_push_t;

	typedef struct packed {
		logic ext;
		logic t16;
		logic t8;
		logic key;
	} irq_req_t;

endpackage : irq_seq_pkg

// ===== testbench/cpu_stack_model.sv
// CPU-side stack model that keeps the bytes pushed on entry and hands them back.
module cpu_stack_model
	import irq_seq_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire stack_push_t push_in,
	input  wire logic        pull_strobe_in,
	input  wire logic [2:0]  pull_sel_in,
	output logic [7:0]       pull_data_out,
	output logic [39:0]      stack_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] ptr_q;
	logic [7:0] last_q;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ptr_q <= 3'h0;
		end else if (push_in.strobe) begin
			stack_out[ptr_q * 8 +: 8] <= push_in.data;
			ptr_q <= (ptr_q == 3'h4) ? 3'h0 : ptr_q + 3'h1;
		end
	end

	// Outside a pull the bus toggles, so a stale byte is never taken for stack data.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			last_q <= 8'h5a;
		end else begin
			last_q <= ~pull_data_out;
		end
	end

	assign pull_data_out = pull_strobe_in ? stack_out[(3'h4 - pull_sel_in) * 8 +: 8] : last_q;
endmodule : cpu_stack_model

// ===== testbench/mcu_interrupt_sequencer_asserts.sv
// Concurrent checks on the ports of the interrupt sequencer.
module mcu_interrupt_sequencer_asserts
	import irq_seq_pkg::*;
(
	input wire logic        core_clk_in,
	input wire logic        rst_b_in,
	input wire logic        insn_boundary_in,
	input wire logic        soft_trap_in,
	input wire logic        return_in,
	input wire logic        clear_mask_in,
	input wire logic [15:0] pc_in,
	input wire logic [7:0]  index_in,
	input wire logic [7:0]  acc_in,
	input wire logic [7:0]  pull_data_in,
	input wire logic        wait_mode_in,
	input wire logic        stop_mode_in,
	input wire stack_push_t push_out,
	input wire logic        vec_load_out,
	input wire logic [15:0] vec_addr_out,
	input wire logic        pull_strobe_out,
	input wire logic [2:0]  pull_sel_out,
	input wire logic        busy_out,
	input wire logic        irq_mask_out,
	input wire logic        wake_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	////////////////////////////////////////////////////////////////////////////////
	a_trap_entry: assert property (
		insn_boundary_in && !busy_out && soft_trap_in && !return_in |=>
		##1 push_out.strobe [*5] ##1 vec_load_out && vec_addr_out == 16'h1ffc)
		else $error("trap entry sequence wrong");
	a_push_order: assert property (
		insn_boundary_in && !busy_out && soft_trap_in && !return_in |=>
		##1 push_out.data == pc_in[7:0] ##1 push_out.data == pc_in[15:8]
		##1 push_out.data == index_in ##1 push_out.data == acc_in)
		else $error("stacking order wrong");
	a_mask_on_vector: assert property (
		vec_load_out |-> irq_mask_out && !busy_out)
		else $error("mask not set at vector load");
	a_pull_order: assert property (
		insn_boundary_in && !busy_out && return_in |=>
		##1 pull_strobe_out && pull_sel_out == 3'h0 ##1 pull_sel_out == 3'h1
		##1 pull_sel_out == 3'h2 ##1 pull_sel_out == 3'h3 ##1 pull_sel_out == 3'h4
		##1 !busy_out && !pull_strobe_out)
		else $error("unstacking order wrong");
	a_mask_restore: assert property (
		pull_strobe_out && pull_sel_out == 3'h0 |=> irq_mask_out == $past(pull_data_in[3]))
		else $error("mask not restored from stack");
	a_masked_hold: assert property (
		insn_boundary_in && !busy_out && irq_mask_out && !soft_trap_in && !return_in
		&& !clear_mask_in |=> !busy_out && !push_out.strobe)
		else $error("entry taken while masked");
	a_busy_span: assert property (
		$rose(busy_out) |-> busy_out [*5] ##1
		(!busy_out or (busy_out && push_out.strobe ##1 !busy_out)))
		else $error("sequence length wrong");
	a_vector_legal: assert property (
		vec_load_out |-> vec_addr_out inside {16'h1ffc, 16'h1ffa, 16'h1ff8, 16'h1ff6, 16'h1ff4})
		else $error("illegal vector address");
	a_no_wake: assert property (
		!wait_mode_in && !stop_mode_in |=> !wake_out)
		else $error("wake outside low power mode");
endmodule : mcu_interrupt_sequencer_asserts

bind mcu_interrupt_sequencer mcu_interrupt_sequencer_asserts i_mcu_interrupt_sequencer_asserts (.*);

// ===== testbench/mcu_interrupt_sequencer_tb_top.sv
// Self-checking bench for the interrupt sequencer with a CPU stack model.
`include "irq_seq_consts.svh"
module mcu_interrupt_sequencer_tb_top
	import irq_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk_in = 1'h0, rst_b_in = 1'h0, ext_drv = 1'h1;
	logic        awvalid_in = 1'h0, wvalid_in = 1'h0, bready_in = 1'h0;
	logic        arvalid_in = 1'h0, rready_in = 1'h0, insn_boundary_in = 1'h0;
	logic        soft_trap_in = 1'h0, return_in = 1'h0, clear_mask_in = 1'h0;
	logic        wait_mode_in = 1'h0, stop_mode_in = 1'h0, capture_event_in = 1'h0;
	logic        compare_event_in = 1'h0, overflow_event_in = 1'h0, byte_timer_zero_in = 1'h0;
	logic        led_on_in = 1'h0, shared_pin_a_in;
	logic [7:0]  awaddr_in = 8'h0, araddr_in = 8'h0, index_in = 8'h0, acc_in = 8'h0;
	logic [7:0]  flags_in = 8'h0, pull_data_in, pullup_en_out, seed = 8'h63;
	logic [31:0] wdata_in = 32'h0, rdata_out, rd;
	logic [3:0]  wstrb_in = 4'hf, key_pins_in = 4'hf;
	logic [15:0] pc_in = 16'h0, vec_addr_out;
	logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, vec_load_out;
	logic        pull_strobe_out, busy_out, irq_mask_out, wake_out, shared_pin_a_oe_out;
	logic [1:0]  bresp_out, rresp_out, rs;
	logic [2:0]  pull_sel_out;
	logic [39:0] stack;
	stack_push_t push_out;
	int          err_count = 0, checks = 0;

	// The pin is open drain: the LED drive wins over whatever the far side offers.
	assign shared_pin_a_in = ext_drv & ~shared_pin_a_oe_out;
	always #25 core_clk_in = ~core_clk_in;

	mcu_interrupt_sequencer i_mcu_interrupt_sequencer (.*);
	cpu_stack_model i_cpu_stack_model (.clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.push_in(push_out), .pull_strobe_in(pull_strobe_out), .pull_sel_in(pull_sel_out),
		.pull_data_out(pull_data_in), .stack_out(stack));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic end_of_test();
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic timeout();
		check(40'h1, 40'h0);
		end_of_test();
	endtask : timeout

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick

	task automatic axi(input logic wr, input logic [7:0] idx, input logic [7:0] dat);
		int n = 0;
		@(posedge core_clk_in);
		{awvalid_in, wvalid_in, bready_in} <= {3{wr}};
		{arvalid_in, rready_in} <= {2{!wr}};
		awaddr_in <= {idx[5:0], 2'h0};
		araddr_in <= {idx[5:0], 2'h0};
		wdata_in <= {24'h0, dat};
		do begin
			@(posedge core_clk_in);
			n++;
			if (awready_out) awvalid_in <= 1'h0;
			if (wready_out) wvalid_in <= 1'h0;
			if (arready_out) arvalid_in <= 1'h0;
		end while (!(wr ? bvalid_out : rvalid_out) && n < 40);
		if (n >= 40) timeout();
		{bready_in, rready_in} <= 2'h0;
		rd = rdata_out;
		rs = wr ? bresp_out : rresp_out;
	endtask : axi

	task automatic pulse_mask_clear();
		@(posedge core_clk_in);
		clear_mask_in <= 1'h1;
		@(posedge core_clk_in);
		clear_mask_in <= 1'h0;
		tick(1);
	endtask : pulse_mask_clear

	// Issues one boundary, checks whether a sequence starts and which vector it loads.
	task automatic step(input logic trap, input logic ret, input logic [15:0] vec,
		input logic taken);
		int n = 0;
		@(posedge core_clk_in);
		{insn_boundary_in, soft_trap_in, return_in} <= {1'h1, trap, ret};
		@(posedge core_clk_in);
		{insn_boundary_in, soft_trap_in, return_in} <= 3'h0;
		#1;
		check(busy_out, taken);
		while (taken && !ret && !vec_load_out && n < 20) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		if (n >= 20) timeout();
		if (taken && !ret) check(vec_addr_out, vec);
		tick(7);
	endtask : step
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(20);
		rst_b_in <= 1'h1;
		axi(1'h0, 8'h0b, 8'h0);
		check(rd, 32'h0);
		axi(1'h0, 8'h0c, 8'h0);
		check(rd, 32'h0);
		axi(1'h0, 8'h1c, 8'h0);
		check(rd[0], 1'h0);
		check(pullup_en_out, 8'h0);
		axi(1'h0, 8'h1f, 8'h0);
		check(rs, `RESP_SLVERR);
		seed = lfsr(seed);
		axi(1'h1, 8'h1d, seed);
		tick(1);
		check(pullup_en_out, seed);
		axi(1'h1, 8'h1c, 8'h00);
		axi(1'h1, 8'h12, 8'h00);
		led_on_in <= 1'h1;
		for (int i = 0; i < 2; i++) begin
			seed = lfsr(seed);
			if (i == 1) pulse_mask_clear();
			pc_in <= {seed, lfsr(seed)};
			index_in <= ~seed;
			acc_in <= seed ^ 8'h5a;
			flags_in <= {seed[7:4], i == 0, seed[2:0]};
			step(1'h1, 1'h0, `VEC_SOFT, 1'h1);
			check(stack, {flags_in, acc_in, index_in, pc_in});
			check(irq_mask_out, 1'h1);
			step(1'h0, 1'h1, 16'h0, 1'h1);
			check(irq_mask_out, i == 0);
		end
		check(shared_pin_a_oe_out, 1'h1);
		ext_drv <= 1'h0;
		tick(5);
		step(1'h0, 1'h0, 16'h0, 1'h0);
		axi(1'h1, 8'h1c, 8'h03);
		tick(1);
		check(shared_pin_a_oe_out, 1'h0);
		step(1'h0, 1'h0, `VEC_EXT, 1'h1);
		pulse_mask_clear();
		step(1'h0, 1'h0, 16'h0, 1'h0);
		ext_drv <= 1'h1;
		tick(5);
		ext_drv <= 1'h0;
		tick(5);
		step(1'h0, 1'h0, `VEC_EXT, 1'h1);
		axi(1'h1, 8'h1c, 8'h01);
		step(1'h0, 1'h0, 16'h0, 1'h0);
		pulse_mask_clear();
		step(1'h0, 1'h0, `VEC_EXT, 1'h1);
		ext_drv <= 1'h1;
		axi(1'h1, 8'h0c, 8'h0f);
		axi(1'h1, 8'h0b, 8'h01);
		key_pins_in <= 4'he;
		tick(5);
		axi(1'h0, 8'h0c, 8'h0);
		check(rd, 32'h1);
		axi(1'h1, 8'h12, 8'h20);
		axi(1'h1, 8'h0d, 8'h40);
		axi(1'h1, 8'h1c, 8'h03);
		@(posedge core_clk_in);
		{overflow_event_in, byte_timer_zero_in, ext_drv} <= 3'h6;
		@(posedge core_clk_in);
		{overflow_event_in, byte_timer_zero_in} <= 2'h0;
		wait_mode_in <= 1'h1;
		tick(5);
		check(wake_out, 1'h1);
		{wait_mode_in, stop_mode_in} <= 2'h1;
		tick(3);
		check(wake_out, 1'h1);
		stop_mode_in <= 1'h0;
		pulse_mask_clear();
		step(1'h0, 1'h0, `VEC_EXT, 1'h1);
		pulse_mask_clear();
		step(1'h0, 1'h0, `VEC_T16, 1'h1);
		axi(1'h0, 8'h13, 8'h0);
		check(rd, 32'h20);
		axi(1'h0, 8'h16, 8'h0);
		axi(1'h0, 8'h13, 8'h0);
		check(rd, 32'h0);
		pulse_mask_clear();
		step(1'h0, 1'h0, `VEC_T8, 1'h1);
		axi(1'h1, 8'h0d, 8'hc0);
		pulse_mask_clear();
		step(1'h0, 1'h0, `VEC_KEY, 1'h1);
		axi(1'h1, 8'h0c, 8'h01);
		axi(1'h0, 8'h0c, 8'h0);
		check(rd, 32'h0);
		pulse_mask_clear();
		step(1'h0, 1'h0, 16'h0, 1'h0);
		end_of_test();
	end
endmodule : mcu_interrupt_sequencer_tb_top
